/* hw/ped_pkg.sv */
// Package for the port error detect register bank: register map, field positions,
// reset values and the carrier types for the register bus and the error strobes.
// Assumes a single 50 MHz clock domain shared with the link-layer error detectors.
package ped_pkg;

  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Byte offsets on the register bus.
  localparam logic [ADDR_W-1:0] OFF_TARGET = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DETECT0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_DETECT_STEP = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h24;

  // Field positions of the port-write target register.
  localparam int unsigned TGT_LOWER_LSB = 16;
  localparam int unsigned TGT_UPPER_LSB = 24;

  // Bit positions of the error detect register.
  localparam int unsigned BIT_VENDOR_FAULT = 31;
  localparam int unsigned BIT_SBIT_PARITY = 23;
  localparam int unsigned BIT_BAD_CRC_CTRL = 22;
  localparam int unsigned BIT_ACK_WRONG_SEQ = 21;
  localparam int unsigned BIT_REJECTION = 20;
  localparam int unsigned BIT_PKT_OUT_OF_SEQ = 19;
  localparam int unsigned BIT_PKT_CRC_FAIL = 18;
  localparam int unsigned BIT_PKT_OVERSIZE = 17;
  localparam int unsigned BIT_RESP_NOT_PENDING = 5;
  localparam int unsigned BIT_PROTOCOL = 4;
  localparam int unsigned BIT_DELINEATION = 2;
  localparam int unsigned BIT_UNREQ_ACK = 1;
  localparam int unsigned BIT_LINK_TIMEOUT = 0;

  // Bits that exist in the error detect register; everything else reads zero.
  localparam logic [DATA_W-1:0] DETECT_IMPL_MASK = 32'h807E0037;
  // Errors for which the capture registers hold no valid information.
  localparam logic [DATA_W-1:0] CAPTURE_INVALID_MASK = 32'h00200025;
  localparam logic [DATA_W-1:0] TARGET_IMPL_MASK = 32'hFFFF0000;

  localparam logic [DATA_W-1:0] RST_TARGET = 32'h00000000;
  localparam logic [DATA_W-1:0] RST_DETECT = 32'h00000000;
  localparam logic [NUM_PORTS-1:0] RST_IRQ = 4'h0;
  localparam logic [DATA_W-1:0] RST_READDATA = 32'h00000000;

  // One-cycle error strobes from a port's link-layer detectors.
  typedef struct packed {
    logic vendor_defined_fault;
    logic bad_crc_ctrl_symbol;
    logic ack_symbol_wrong_seq;
    logic rejection_symbol_seen;
    logic packet_out_of_sequence;
    logic packet_crc_fail;
    logic packet_oversize;
    logic response_seq_not_pending;
    logic protocol_error;
    logic delineation_error;
    logic unrequested_ack_seen;
    logic link_timeout;
  } ped_err_evt_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [3:0] byteenable;
  } ped_av_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
  } ped_av_rsp_t;

  // Places each strobe on its register bit. The S-bit parity bit has no source.
  function automatic logic [DATA_W-1:0] ped_evt_bits(input ped_err_evt_t e);
    logic [DATA_W-1:0] v;
    v = 32'h00000000;
    v[BIT_VENDOR_FAULT] = e.vendor_defined_fault; // see RULE_04
    v[BIT_SBIT_PARITY] = 1'b0; // see RULE_05
    v[BIT_BAD_CRC_CTRL] = e.bad_crc_ctrl_symbol; // see RULE_06
    v[BIT_ACK_WRONG_SEQ] = e.ack_symbol_wrong_seq; // see RULE_07
    v[BIT_REJECTION] = e.rejection_symbol_seen; // see RULE_08
    v[BIT_PKT_OUT_OF_SEQ] = e.packet_out_of_sequence; // see RULE_09
    v[BIT_PKT_CRC_FAIL] = e.packet_crc_fail; // see RULE_10
    v[BIT_PKT_OVERSIZE] = e.packet_oversize; // see RULE_11
    v[BIT_RESP_NOT_PENDING] = e.response_seq_not_pending; // see RULE_12
    v[BIT_PROTOCOL] = e.protocol_error; // see RULE_13
    v[BIT_DELINEATION] = e.delineation_error; // see RULE_14
    v[BIT_UNREQ_ACK] = e.unrequested_ack_seen; // see RULE_15
    v[BIT_LINK_TIMEOUT] = e.link_timeout; // see RULE_16
    return v;
  endfunction

endpackage

/* hw/ped_regs.sv */
// Port error detect register bank: port-write target register, four per-port
// error detect registers that clear on read, and a sticky interrupt per port.
// Assumes an Avalon-MM master on clk and error strobes generated on the same clock.
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none

//Contract
// RULE_01: Target register bits 23-16 hold a writable 8-bit port-write destination ID.
// RULE_02: Bits 31-24 hold the upper target ID byte, used only with large transport.
// RULE_03: Four error detect registers, each logging only its own port's errors.
// RULE_04: Bit 31 sets on a vendor-defined fault such as an unsupported transaction.
// RULE_05: Bit 23 is reserved and never set on a serial link.
// RULE_06: Bit 22 sets when a control symbol fails its CRC.
// RULE_07: Bit 21 sets on an accept or retry acknowledge with the wrong ackID.
// RULE_08: Bit 20 sets on every received packet-not-accepted symbol.
// RULE_09: Bit 19 sets on a received packet with an out-of-sequence ackID.
// RULE_10: Bit 18 sets on a received packet failing its CRC.
// RULE_11: Bit 17 sets on a received packet longer than 276 bytes.
// RULE_12: Bit 5 sets on a link-response naming no outstanding packet.
// RULE_13: Bit 4 sets on a packet or symbol unexpected in the protocol state.
// RULE_14: Bit 2 sets on a misaligned delimiter or an undefined code-group.
// RULE_15: Bit 1 sets on an acknowledge that no transmitted packet solicited.
// RULE_16: Bit 0 sets when an acknowledge or link-response times out.
// RULE_17: Bits 21, 5, 2 and 0 do not mark capture information as valid.
// RULE_18: Detect bits stay set until read; the read returns and clears them.
module ped_regs
  import ped_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire ped_av_req_t av_req,
  output ped_av_rsp_t av_rsp_q,
  input wire ped_err_evt_t [NUM_PORTS-1:0] port_evt,
  input wire logic large_transport,
  output logic [15:0] pw_dest_id_q,
  output logic [NUM_PORTS-1:0] capture_valid_q,
  output logic irq_q
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic [DATA_W-1:0] target_q;
  logic [DATA_W-1:0] target_d;
  logic [DATA_W-1:0] detect_q [NUM_PORTS];
  logic [DATA_W-1:0] evt_set [NUM_PORTS];
  logic [NUM_PORTS-1:0] det_sel;
  logic [NUM_PORTS-1:0] irq_stat_q;
  logic [NUM_PORTS-1:0] irq_stat_d;
  logic [NUM_PORTS-1:0] irq_mask_q;
  logic [NUM_PORTS-1:0] port_hit;
  logic [DATA_W-1:0] rd_mux;
  logic req;
  logic rd_done;
  logic wr_done;
  logic [DATA_W-1:0] wmask;

  // A request is taken on the second edge after it appears, when waitrequest is low.
  // The single wait cycle lets read data come from a flip-flop.
  assign req = av_req.read | av_req.write;
  assign rd_done = av_req.read & ~av_rsp_q.waitrequest;
  assign wr_done = av_req.write & ~av_rsp_q.waitrequest;

  always_comb begin
    wmask = {{8{av_req.byteenable[3]}}, {8{av_req.byteenable[2]}},
             {8{av_req.byteenable[1]}}, {8{av_req.byteenable[0]}}};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      av_rsp_q.waitrequest <= 1'b1;
    end else if (req && av_rsp_q.waitrequest) begin
      av_rsp_q.waitrequest <= 1'b0;
    end else begin
      av_rsp_q.waitrequest <= 1'b1;
    end
  end

  // Read data is sampled in the wait cycle, so the value returned is exactly the
  // value that the completing read then clears; later events survive the clear.
  always_comb begin
    rd_mux = 32'h00000000;
    if (av_req.address == OFF_TARGET) begin
      rd_mux = target_q & TARGET_IMPL_MASK;
    end else if (av_req.address == OFF_IRQ_STATUS) begin
      rd_mux = {{(DATA_W-NUM_PORTS){1'b0}}, irq_stat_q};
    end else if (av_req.address == OFF_IRQ_MASK) begin
      rd_mux = {{(DATA_W-NUM_PORTS){1'b0}}, irq_mask_q};
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (det_sel[i]) begin
          rd_mux = detect_q[i] & DETECT_IMPL_MASK; // see RULE_18
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      av_rsp_q.readdata <= RST_READDATA;
    end else if (av_req.read && av_rsp_q.waitrequest) begin
      av_rsp_q.readdata <= rd_mux;
    end
  end

  // Port-write target. The low half is reserved and never stored.
  always_comb begin
    target_d = target_q;
    if (wr_done && av_req.address == OFF_TARGET) begin
      target_d = ((target_q & ~wmask) | (av_req.writedata & wmask)) & TARGET_IMPL_MASK; // see RULE_01
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      target_q <= RST_TARGET;
    end else begin
      target_q <= target_d;
    end
  end

  // Small transport systems see only the lower byte; the upper is forced to zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      pw_dest_id_q <= 16'h0000;
    end else if (large_transport) begin
      // Both bytes sit side by side from the lower field upwards.
      pw_dest_id_q <= target_q[TGT_LOWER_LSB +: 16]; // see RULE_02
    end else begin
      pw_dest_id_q <= {8'h00, target_q[TGT_LOWER_LSB +: 8]}; // see RULE_01
    end
  end

  // One detect register per port, fed only by that port's strobes.
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    localparam logic [ADDR_W-1:0] PORT_OFF = OFF_DETECT0 + ADDR_W'(p * 4);
    logic [DATA_W-1:0] clr;

    assign det_sel[p] = (av_req.address == PORT_OFF);
    assign evt_set[p] = ped_evt_bits(port_evt[p]) & DETECT_IMPL_MASK; // see RULE_03
    assign clr = (rd_done && det_sel[p]) ? av_rsp_q.readdata : 32'h00000000;
    assign port_hit[p] = |evt_set[p];

    // Set wins over the read clear so an event in the clearing cycle is kept.
    always_ff @(posedge clk) begin
      if (rst) begin
        detect_q[p] <= RST_DETECT;
      end else begin
        detect_q[p] <= (detect_q[p] & ~clr) | evt_set[p]; // see RULE_18
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        capture_valid_q[p] <= 1'b0;
      end else begin
        capture_valid_q[p] <= |(evt_set[p] & ~CAPTURE_INVALID_MASK); // see RULE_17
      end
    end

    AST_SET_STICKY: assert property (
      port_hit[p] |=> ((detect_q[p] & $past(evt_set[p])) == $past(evt_set[p])))
      else $error("error strobe did not set its detect bit"); // see RULE_03

    AST_NO_PARITY: assert property (detect_q[p][BIT_SBIT_PARITY] == 1'b0)
      else $error("reserved parity bit was set"); // see RULE_05

    AST_HOLD_UNTIL_READ: assert property (
      (detect_q[p][BIT_PKT_OVERSIZE] && !(rd_done && det_sel[p]))
      |=> detect_q[p][BIT_PKT_OVERSIZE])
      else $error("detect bit dropped without a read"); // see RULE_18

    AST_READ_CLEARS: assert property (
      (rd_done && det_sel[p] && !port_hit[p])
      |=> ((detect_q[p] & $past(av_rsp_q.readdata)) == 32'h00000000))
      else $error("read did not clear the reported bits"); // see RULE_18

    AST_OWN_PORT: assert property (
      $rose(detect_q[p][BIT_PKT_CRC_FAIL]) |-> $past(port_evt[p].packet_crc_fail))
      else $error("detect bit set without its own port strobe"); // see RULE_10

    AST_TIMEOUT_NO_CAPTURE: assert property (
      (port_evt[p] == ped_err_evt_t'(12'h001)) |=> !capture_valid_q[p])
      else $error("time-out marked capture as valid"); // see RULE_17

    AST_OVERSIZE_CAPTURE: assert property (
      port_evt[p].packet_oversize |=> capture_valid_q[p])
      else $error("oversize packet did not mark capture as valid"); // see RULE_11

    // Each strobe must land on its own bit one edge later, whatever else happens.
    // A read clear in the same cycle must not hide it, since set wins.
    AST_CTRL_CRC: assert property ( // see RULE_06
      port_evt[p].bad_crc_ctrl_symbol |=> detect_q[p][BIT_BAD_CRC_CTRL])
      else $error("corrupt control symbol did not set bit 22");

    AST_ACK_SEQ: assert property ( // see RULE_07
      port_evt[p].ack_symbol_wrong_seq |=> detect_q[p][BIT_ACK_WRONG_SEQ])
      else $error("wrong acknowledge sequence did not set bit 21");

    AST_REJECT: assert property ( // see RULE_08
      port_evt[p].rejection_symbol_seen |=> detect_q[p][BIT_REJECTION])
      else $error("rejection symbol did not set bit 20");

    AST_PKT_SEQ: assert property ( // see RULE_09
      port_evt[p].packet_out_of_sequence |=> detect_q[p][BIT_PKT_OUT_OF_SEQ])
      else $error("out of sequence packet did not set bit 19");

    AST_PKT_CRC: assert property ( // see RULE_10
      port_evt[p].packet_crc_fail |=> detect_q[p][BIT_PKT_CRC_FAIL])
      else $error("packet crc failure did not set bit 18");

    AST_RESP_PEND: assert property ( // see RULE_12
      port_evt[p].response_seq_not_pending |=> detect_q[p][BIT_RESP_NOT_PENDING])
      else $error("non pending response did not set bit 5");

    AST_PROTOCOL: assert property ( // see RULE_13
      port_evt[p].protocol_error |=> detect_q[p][BIT_PROTOCOL])
      else $error("protocol error did not set bit 4");

    AST_DELIN: assert property ( // see RULE_14
      port_evt[p].delineation_error |=> detect_q[p][BIT_DELINEATION])
      else $error("delineation error did not set bit 2");

    AST_UNREQ_ACK: assert property ( // see RULE_15
      port_evt[p].unrequested_ack_seen |=> detect_q[p][BIT_UNREQ_ACK])
      else $error("unrequested acknowledge did not set bit 1");

    AST_LINK_TO: assert property ( // see RULE_16
      port_evt[p].link_timeout |=> detect_q[p][BIT_LINK_TIMEOUT])
      else $error("link time-out did not set bit 0");

    AST_RESERVED_ZERO: assert property ( // see RULE_18
      (detect_q[p] & ~DETECT_IMPL_MASK) == 32'h00000000)
      else $error("reserved detect bit was set");

    // Errors without capture data, or no error at all, must never pulse capture valid.
    AST_NO_CAPTURE: assert property ( // see RULE_17
      !(|(evt_set[p] & ~CAPTURE_INVALID_MASK)) |=> !capture_valid_q[p])
      else $error("capture marked valid without a capture-worthy error");

    AST_CAPTURE_CAUSE: assert property ( // see RULE_17
      capture_valid_q[p] |-> $past(port_hit[p]))
      else $error("capture valid pulse without an error strobe");

    AST_IRQ_STAT_SET: assert property ( // see RULE_03
      port_hit[p] |=> irq_stat_q[p])
      else $error("port error did not set its interrupt status bit");

    AST_IRQ_W1C: assert property (
      (wr_done && av_req.address == OFF_IRQ_STATUS && av_req.writedata[p] && !port_hit[p])
      |=> !irq_stat_q[p])
      else $error("writing one did not clear the interrupt status bit");

    AST_IRQ_STAT_HOLD: assert property (
      (irq_stat_q[p] && !(wr_done && av_req.address == OFF_IRQ_STATUS && av_req.writedata[p]))
      |=> irq_stat_q[p])
      else $error("interrupt status bit dropped without a clear");
  end

  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr_done && av_req.address == OFF_IRQ_STATUS) begin
      irq_stat_d = irq_stat_q & ~av_req.writedata[NUM_PORTS-1:0];
    end
    irq_stat_d = irq_stat_d | port_hit;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_q <= RST_IRQ;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask_q <= RST_IRQ;
    end else if (wr_done && av_req.address == OFF_IRQ_MASK) begin
      irq_mask_q <= av_req.writedata[NUM_PORTS-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  AST_TARGET_WRITE: assert property (
    (wr_done && av_req.address == OFF_TARGET && av_req.byteenable[2])
    |=> ##1 (pw_dest_id_q[7:0] == $past(av_req.writedata[23:16], 2)))
    else $error("target lower byte not taken from the write"); // see RULE_01

  AST_UPPER_SMALL: assert property (
    !large_transport |=> (pw_dest_id_q[15:8] == 8'h00))
    else $error("upper target byte used without large transport"); // see RULE_02

  AST_VENDOR_FAULT: assert property (
    port_evt[0].vendor_defined_fault |=> detect_q[0][BIT_VENDOR_FAULT])
    else $error("vendor fault did not set bit 31"); // see RULE_04

  AST_WAIT_ONE: assert property (
    (req && av_rsp_q.waitrequest) |=> !av_rsp_q.waitrequest ##1 av_rsp_q.waitrequest)
    else $error("waitrequest did not drop for exactly one cycle");

  AST_IRQ_LEVEL: assert property (
    (|(port_hit & irq_mask_q)) |=> ##1 irq_q)
    else $error("unmasked error did not raise the interrupt");

  // The interrupt output lags the status by one register stage, never more.
  AST_IRQ_LOW: assert property (
    ((irq_stat_q & irq_mask_q) == 4'h0) |=> !irq_q)
    else $error("interrupt high with no unmasked status bit");

  AST_MASK_WRITE: assert property (
    (wr_done && av_req.address == OFF_IRQ_MASK)
    |=> (irq_mask_q == $past(av_req.writedata[NUM_PORTS-1:0])))
    else $error("mask write did not land");

  AST_TARGET_LOW_ZERO: assert property ( // see RULE_01
    target_q[15:0] == 16'h0000)
    else $error("reserved target bits were stored");

  AST_UPPER_LARGE: assert property ( // see RULE_02
    large_transport |=> (pw_dest_id_q == $past(target_q[31:16])))
    else $error("large transport target not taken from both bytes");

  // Waitrequest only drops to answer a request; idle cycles keep it high.
  AST_WAIT_IDLE: assert property (
    !av_rsp_q.waitrequest |-> $past(req))
    else $error("waitrequest dropped without a request");

  AST_READ_HOLD: assert property (
    !(av_req.read && av_rsp_q.waitrequest) |=> $stable(av_rsp_q.readdata))
    else $error("read data changed outside a read");

endmodule

`default_nettype wire

/* tb/ped_link_partner.sv */
// Behavioural stand-in for the link-layer error detectors facing the remote partner.
// Assumes it shares clk with the register bank and is driven by bench task calls.
`timescale 1ns/1ps
`default_nettype none
module ped_link_partner
  import ped_pkg::*;
(
  input wire logic clk,
  output var ped_err_evt_t [NUM_PORTS-1:0] port_evt
);
  initial port_evt = '0;
  // A strobe lasts one cycle; a held level would log the error again every cycle.
  task automatic fire(input int p, input ped_err_evt_t e);
    @(posedge clk);
    port_evt[p] <= e;
    @(posedge clk);
    port_evt[p] <= '0;
  endtask
endmodule
`default_nettype wire

/* tb/port_error_detect_regs_bench.sv */
// Self-checking bench for the port error detect register bank.
// Assumes the partner model drives the error strobes on the bench clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module port_error_detect_regs_bench;
  import ped_pkg::*;
  typedef struct packed {logic [1:0] port; logic [11:0] evt; logic [31:0] det; logic cv;} ped_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic large_transport = 1'b0;
  ped_av_req_t req = '0;
  ped_av_rsp_t rsp;
  ped_err_evt_t [NUM_PORTS-1:0] port_evt;
  logic [15:0] dest;
  logic [NUM_PORTS-1:0] cv;
  logic irq;
  logic [31:0] rd;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  ped_row_t rows [12] = '{
    '{2'd0, 12'h800, 32'h80000000, 1'b1},
    '{2'd1, 12'h400, 32'h00400000, 1'b1},
    '{2'd2, 12'h200, 32'h00200000, 1'b0},
    '{2'd3, 12'h100, 32'h00100000, 1'b1},
    '{2'd0, 12'h080, 32'h00080000, 1'b1},
    '{2'd1, 12'h040, 32'h00040000, 1'b1},
    '{2'd2, 12'h020, 32'h00020000, 1'b1},
    '{2'd3, 12'h010, 32'h00000020, 1'b0},
    '{2'd0, 12'h008, 32'h00000010, 1'b1},
    '{2'd1, 12'h004, 32'h00000004, 1'b0},
    '{2'd2, 12'h002, 32'h00000002, 1'b1},
    '{2'd3, 12'h001, 32'h00000001, 1'b0}};

  ped_regs u_dut (.clk(clk), .rst(rst), .av_req(req), .av_rsp_q(rsp), .port_evt(port_evt),
    .large_transport(large_transport), .pw_dest_id_q(dest), .capture_valid_q(cv), .irq_q(irq));
  ped_link_partner u_partner (.clk(clk), .port_evt(port_evt));

  initial begin
    forever #10 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // The request is held until waitrequest is seen low; the wait is bounded by the timeout.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    req.read <= ~wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= 4'hF;
    do @(posedge clk); while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, OFF_TARGET, 32'h0, rd);
    `CHK("target reset", 32'h0, rd)
    bus(1'b1, OFF_TARGET, 32'hA5C31234, rd);
    bus(1'b0, OFF_TARGET, 32'h0, rd);
    `CHK("target", 32'hA5C30000, rd)
    `CHK("dest small", 16'h00C3, dest)
    large_transport <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("dest large", 16'hA5C3, dest)
    $display("test target done");
    for (int i = 0; i < 12; i++) begin
      u_partner.fire(rows[i].port, rows[i].evt);
      #1;
      `CHK("capture valid", 4'({3'h0, rows[i].cv} << rows[i].port), cv)
      for (int p = 0; p < 4; p++) begin
        bus(1'b0, OFF_DETECT0 + 8'(4 * p), 32'h0, rd);
        `CHK("detect", (p == rows[i].port) ? rows[i].det : 32'h0, rd)
      end
      bus(1'b0, OFF_DETECT0 + 8'(4 * rows[i].port), 32'h0, rd);
      `CHK("detect cleared", 32'h0, rd)
    end
    $display("test events done");
    // Every strobe at once, then a write that must not disturb the logged bits.
    u_partner.fire(3, '1);
    bus(1'b1, OFF_DETECT0 + 8'h0C, 32'hFFFFFFFF, rd);
    bus(1'b0, OFF_DETECT0 + 8'h0C, 32'h0, rd);
    `CHK("all events", 32'h807E0037, rd)
    bus(1'b0, 8'h40, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    $display("test awkward done");
    `CHK("irq masked", 1'b0, irq)
    bus(1'b1, OFF_IRQ_MASK, 32'h4, rd);
    bus(1'b0, OFF_IRQ_STATUS, 32'h0, rd);
    `CHK("irq status", 32'hF, rd)
    `CHK("irq on", 1'b1, irq)
    bus(1'b1, OFF_IRQ_STATUS, 32'h4, rd);
    repeat (2) @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    u_partner.fire(2, 12'h001);
    repeat (2) @(posedge clk);
    `CHK("irq again", 1'b1, irq)
    $display("test irq done");
    end_of_test();
  end
endmodule
`default_nettype wire
